// ==== power_mode_reset_control.sv ====
// Power-mode selection, clock source switching and reset-source control with APB registers
`timescale 1ns/1ns
// How it works
// - Halt-select bit decides idle or sleep when low-power
// - Select field picks primary, secondary or internal
// - Select change switches clock at once when running
// - Only sleep instruction enters idle or sleep
// - Halt-select zero: sleep, all clocks off
// - Halt-select one: CPU off, peripherals keep clock
// - Run modes clock CPU and peripherals
// - Halt-select sampled when sleep instruction executes
// - Internal block: fast oscillator, postscaler, slow RC
// - Record which of eight causes reset occurred
// - Filtered low reset pin resets device
// - Reset pin never driven low by device
// - Disabled reset pin acts as digital input
// - Power-on pulse initialises every register
// - Power-on clears flag; only a software write sets it
module power_mode_reset_control (
  input wire logic clk,
  input wire logic rst_n, // On-chip power-on reset pulse
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepExec, // Sleep instruction executes, one cycle
  input wire logic wakeEvent, // Wake-up request, one cycle
  input wire logic [2:0] srcRunning, // Primary, secondary, internal stable
  input wire pmrc_pkg::pmrc_rstreq_t rstReq, // Internally generated resets
  input wire logic externalResetPinIn, // external_reset_pin level
  input wire logic externalResetPinEnable, // Configuration bit
  output logic externalResetPinOut, // Pin output value
  output logic externalResetPinOe, // Pin output enable
  output logic pinDigitalIn, // Pin as a plain input
  output pmrc_pkg::pmrc_clk_t clkCtrl,
  output logic sysReset, // Device-wide reset
  output pmrc_pkg::pmrc_mode_t mode,
  output logic irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] oscCtrl; // Halt select and clock select
    logic porFlag; // Low after power-on
    pmrc_pkg::pmrc_cause_t cause; // Last reset cause
    pmrc_pkg::pmrc_mode_t mode; // Current power mode
    logic [1:0] activeSrc; // Source actually in use
    logic [7:0] lowCnt; // Pin low samples
    logic pinHeld; // Filtered pin reset
    logic inReset; // A reset is being applied
    logic [4:0] irqStat; // Sticky events
    logic [4:0] irqEn; // Enables
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pmrc_pkg::pmrc_clk_t clk; // Registered clock controls
    logic pinDin;
    logic irq;
  } pmrc_state_t;

  pmrc_state_t state_r;
  pmrc_state_t state_nxt;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Fold 1x onto the internal code
  function automatic logic [1:0] pmrc_decode_src(input logic [1:0] sel);
    pmrc_decode_src = sel[1] ? pmrc_pkg::CSS_INTERNAL : sel;
  endfunction

  // Whether a source code is currently stable
  function automatic logic pmrc_src_ok(input logic [1:0] src, input logic [2:0] run);
    pmrc_src_ok = run[src];
  endfunction

  logic apbSetup; // Setup phase seen
  logic apbWr; // Write takes effect this edge
  logic [1:0] wantSrc; // Decoded select field
  logic anyInt; // Any internal reset request
  logic newReset; // First cycle of a reset

  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && state_r.pready && pwrite;
  assign wantSrc = pmrc_decode_src(state_r.oscCtrl[pmrc_pkg::CSS_LSB +: 2]);
  assign anyInt = |rstReq;
  assign newReset = (state_r.pinHeld || anyInt) && !state_r.inReset;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [4:0] ev;
    logic [4:0] clr;
    logic isMapped;
    ev = '0;
    clr = '0;
    isMapped = 1'b0;
    state_nxt = state_r;

    // APB register writes
    if (apbWr) begin
      unique case (paddr)
        pmrc_pkg::OFF_OSC_CTRL: begin
          // Only halt select and clock select are storable
          state_nxt.oscCtrl = '0;
          state_nxt.oscCtrl[pmrc_pkg::HALT_SEL_BIT] = pwdata[pmrc_pkg::HALT_SEL_BIT];
          state_nxt.oscCtrl[pmrc_pkg::CSS_LSB +: 2] = pwdata[pmrc_pkg::CSS_LSB +: 2];
        end
        pmrc_pkg::OFF_RST_CTRL: begin
          // Software may only set the flag, never clear it
          if (pwdata[pmrc_pkg::POR_FLAG_BIT]) begin
            state_nxt.porFlag = 1'b1;
          end
        end
        pmrc_pkg::OFF_IRQ_EN: begin
          state_nxt.irqEn = pwdata[4:0];
        end
        pmrc_pkg::OFF_IRQ_CLR: begin
          clr = pwdata[4:0];
        end
        default: begin
          // Read-only or unmapped: no effect
        end
      endcase
    end

    // Immediate switch, but never onto a source that is not yet stable
    if (state_r.mode != pmrc_pkg::PMRC_SLEEP && wantSrc != state_r.activeSrc
        && pmrc_src_ok(wantSrc, srcRunning)) begin
      state_nxt.activeSrc = wantSrc;
      ev[pmrc_pkg::EV_CLKSW] = 1'b1;
    end

    // Power mode sequencing
    unique case (state_r.mode)
      pmrc_pkg::PMRC_RUN: begin
        // Halt select is read at the instruction, not later
        if (sleepExec) begin
          if (state_r.oscCtrl[pmrc_pkg::HALT_SEL_BIT]) begin
            state_nxt.mode = pmrc_pkg::PMRC_IDLE;
            ev[pmrc_pkg::EV_IDLE] = 1'b1;
          end else begin
            state_nxt.mode = pmrc_pkg::PMRC_SLEEP;
            ev[pmrc_pkg::EV_SLEEP] = 1'b1;
          end
        end
      end
      pmrc_pkg::PMRC_IDLE, pmrc_pkg::PMRC_SLEEP: begin
        if (wakeEvent) begin
          state_nxt.mode = pmrc_pkg::PMRC_RUN;
          state_nxt.activeSrc = wantSrc;
          ev[pmrc_pkg::EV_WAKE] = 1'b1;
        end
      end
      default: begin
        state_nxt.mode = pmrc_pkg::PMRC_RUN;
      end
    endcase

    // Noise filter: a low shorter than the filter time never resets
    if (!externalResetPinIn && externalResetPinEnable) begin
      if (state_r.lowCnt < 8'(pmrc_pkg::PIN_FILTER_CYC)) begin
        state_nxt.lowCnt = state_r.lowCnt + 8'h01;
      end
    end else begin
      state_nxt.lowCnt = '0;
    end
    state_nxt.pinHeld = (state_nxt.lowCnt >= 8'(pmrc_pkg::PIN_FILTER_CYC));

    // Reset cause capture, first cause of a reset wins
    state_nxt.inReset = state_r.pinHeld || anyInt;
    if (newReset) begin
      ev[pmrc_pkg::EV_RESET] = 1'b1;
      // Device reset returns to full-power run with default selects
      state_nxt.mode = pmrc_pkg::PMRC_RUN;
      state_nxt.oscCtrl = pmrc_pkg::OSC_CTRL_RST;
      state_nxt.activeSrc = pmrc_pkg::CSS_PRIMARY;
      if (state_r.pinHeld) begin
        state_nxt.cause = (state_r.mode == pmrc_pkg::PMRC_SLEEP) ?
          pmrc_pkg::CAUSE_PIN_SLEEP : pmrc_pkg::CAUSE_PIN_RUN;
      end else if (rstReq.brownOut) begin
        state_nxt.cause = pmrc_pkg::CAUSE_BROWN_OUT;
      end else if (rstReq.watchdog) begin
        state_nxt.cause = pmrc_pkg::CAUSE_WATCHDOG;
      end else if (rstReq.stackFull) begin
        state_nxt.cause = pmrc_pkg::CAUSE_STACK_FULL;
      end else if (rstReq.stackUnder) begin
        state_nxt.cause = pmrc_pkg::CAUSE_STACK_UNDER;
      end else begin
        state_nxt.cause = pmrc_pkg::CAUSE_RESET_INSTR;
      end
      // The power-on flag is left alone by these resets
      state_nxt.porFlag = state_r.porFlag;
    end

    // Sticky events: a new event beats a clear in the same cycle
    state_nxt.irqStat = (state_r.irqStat & ~clr) | ev;
    state_nxt.irq = |(state_nxt.irqStat & state_nxt.irqEn);

    // Clock controls, from the next mode so they follow without extra lag
    state_nxt.clk = '0;
    state_nxt.clk.src = state_nxt.activeSrc;
    if (state_nxt.mode != pmrc_pkg::PMRC_SLEEP) begin
      // Idle stops only the CPU; run keeps both going
      state_nxt.clk.cpuEn = (state_nxt.mode == pmrc_pkg::PMRC_RUN);
      state_nxt.clk.periphEn = 1'b1;
      state_nxt.clk.primaryEn = (state_nxt.activeSrc == pmrc_pkg::CSS_PRIMARY);
      state_nxt.clk.secondaryEn = (state_nxt.activeSrc == pmrc_pkg::CSS_SECONDARY);
      state_nxt.clk.fastEn = (state_nxt.activeSrc == pmrc_pkg::CSS_INTERNAL);
      state_nxt.clk.postEn = (state_nxt.activeSrc == pmrc_pkg::CSS_INTERNAL);
      state_nxt.clk.slowEn = (state_nxt.activeSrc == pmrc_pkg::CSS_INTERNAL);
    end

    // Disabled reset function turns the pin into a plain input
    state_nxt.pinDin = externalResetPinEnable ? 1'b0 : externalResetPinIn;

    // APB answer: ready one cycle after setup
    state_nxt.pready = apbSetup;
    state_nxt.pslverr = 1'b0;
    if (apbSetup) begin
      state_nxt.prdata = '0;
      isMapped = 1'b1;
      unique case (paddr)
        pmrc_pkg::OFF_OSC_CTRL: begin
          state_nxt.prdata[7:0] = state_r.oscCtrl;
        end
        pmrc_pkg::OFF_RST_CTRL: begin
          state_nxt.prdata[pmrc_pkg::POR_FLAG_BIT] = state_r.porFlag;
          state_nxt.prdata[pmrc_pkg::CAUSE_LSB +: 4] = state_r.cause;
        end
        pmrc_pkg::OFF_MODE: begin
          state_nxt.prdata[1:0] = state_r.mode;
          state_nxt.prdata[5:4] = state_r.activeSrc;
        end
        pmrc_pkg::OFF_IRQ_STAT: begin
          state_nxt.prdata[4:0] = state_r.irqStat;
        end
        pmrc_pkg::OFF_IRQ_EN: begin
          state_nxt.prdata[4:0] = state_r.irqEn;
        end
        pmrc_pkg::OFF_IRQ_CLR: begin
          // Write only, reads as zero
        end
        default: begin
          isMapped = 1'b0;
        end
      endcase
      state_nxt.pslverr = !isMapped;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Power-on: every field to its initial value, flag low
      state_r <= '0;
      state_r.porFlag <= 1'b0;
      state_r.cause <= pmrc_pkg::CAUSE_POWER_ON;
      state_r.mode <= pmrc_pkg::PMRC_RUN;
      state_r.oscCtrl <= pmrc_pkg::OSC_CTRL_RST;
      state_r.irqStat <= pmrc_pkg::IRQ_RST;
      state_r.irqEn <= pmrc_pkg::IRQ_RST;
      state_r.clk.cpuEn <= 1'b1;
      state_r.clk.periphEn <= 1'b1;
      state_r.clk.primaryEn <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic pinOut_r; // Always low value, never enabled
  logic pinOe_r;
  logic sysReset_r;

  // Pin is an input only; the device never pulls it
  always_ff @(posedge clk) begin
    pinOut_r <= 1'b0;
    pinOe_r <= 1'b0;
    sysReset_r <= !rst_n || state_r.pinHeld || anyInt;
  end

  assign externalResetPinOut = pinOut_r;
  assign externalResetPinOe = pinOe_r;
  assign sysReset = sysReset_r;
  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign clkCtrl = state_r.clk;
  assign mode = state_r.mode;
  assign irq = state_r.irq;
  assign pinDigitalIn = state_r.pinDin;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sleep_cmd;
    sleepExec && state_r.mode == pmrc_pkg::PMRC_RUN && !newReset;
  endsequence

  property p_idle_entry;
    s_sleep_cmd and state_r.oscCtrl[7] |=> mode == pmrc_pkg::PMRC_IDLE
      ##0 !clkCtrl.cpuEn && clkCtrl.periphEn;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

  property p_sleep_entry;
    s_sleep_cmd and !state_r.oscCtrl[7] |=> clkCtrl[8:2] == 7'h00;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not all off");

  property p_no_lowpower_without_cmd;
    $past(mode) == pmrc_pkg::PMRC_RUN && mode != pmrc_pkg::PMRC_RUN |-> $past(sleepExec);
  endproperty
  a_no_lowpower_without_cmd: assert property (p_no_lowpower_without_cmd)
    else $error("low power without sleep");

  property p_run_clocks;
    mode == pmrc_pkg::PMRC_RUN |-> clkCtrl.cpuEn && clkCtrl.periphEn;
  endproperty
  a_run_clocks: assert property (p_run_clocks) else $error("run clocks off");

  property p_switch;
    mode == pmrc_pkg::PMRC_RUN && !newReset && wantSrc != state_r.activeSrc
      && srcRunning[wantSrc] |=> clkCtrl.src == $past(wantSrc);
  endproperty
  a_switch: assert property (p_switch) else $error("clock switch late");

  property p_internal_set;
    clkCtrl.src == pmrc_pkg::CSS_INTERNAL && mode != pmrc_pkg::PMRC_SLEEP
      |-> clkCtrl.fastEn && clkCtrl.postEn && clkCtrl.slowEn;
  endproperty
  a_internal_set: assert property (p_internal_set) else $error("internal block off");

  property p_pin_never_driven;
    !externalResetPinOe;
  endproperty
  a_pin_never_driven: assert property (p_pin_never_driven) else $error("pin driven");

  property p_short_pulse;
    externalResetPinIn ##1 !externalResetPinIn [*8] ##1 externalResetPinIn
      |-> !state_r.pinHeld [*2];
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse reset");

  property p_pin_disabled;
    !externalResetPinEnable |=> !state_r.pinHeld;
  endproperty
  a_pin_disabled: assert property (p_pin_disabled) else $error("disabled pin reset");

  property p_flag_no_hw_set;
    !state_r.porFlag && !apbWr |=> !state_r.porFlag;
  endproperty
  a_flag_no_hw_set: assert property (p_flag_no_hw_set) else $error("flag set by hw");

  property p_wake;
    mode != pmrc_pkg::PMRC_RUN && wakeEvent && !newReset
      |=> mode == pmrc_pkg::PMRC_RUN && clkCtrl.cpuEn;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not to run");

  property p_cause_pin_sleep;
    newReset && state_r.pinHeld && state_r.mode == pmrc_pkg::PMRC_SLEEP
      |=> state_r.cause == pmrc_pkg::CAUSE_PIN_SLEEP;
  endproperty
  a_cause_pin_sleep: assert property (p_cause_pin_sleep) else $error("cause wrong");

endmodule

// ==== pmrc_pkg.sv ====
// Package with offsets, fields, reset values, timing and types of the power-mode/reset block
package pmrc_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_OSC_CTRL = 8'h00; // oscillator_control_reg
  localparam logic [7:0] OFF_RST_CTRL = 8'h04; // reset_control_reg
  localparam logic [7:0] OFF_MODE = 8'h08; // Current mode, read only
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c; // Sticky events, read only
  localparam logic [7:0] OFF_IRQ_EN = 8'h10; // Interrupt enables
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14; // Write one to clear, write only

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int HALT_SEL_BIT = 7; // cpu_halt_select
  localparam int CSS_LSB = 0; // clock_source_select, bits 1:0
  localparam int POR_FLAG_BIT = 1; // Power-on flag, low after power-on
  localparam int CAUSE_LSB = 8; // Last reset cause, bits 11:8
  localparam logic [7:0] OSC_CTRL_RST = 8'h00;
  localparam logic [4:0] IRQ_RST = 5'h00;
  localparam int EV_SLEEP = 0; // Entered sleep
  localparam int EV_IDLE = 1; // Entered an idle mode
  localparam int EV_WAKE = 2; // Woke to run
  localparam int EV_CLKSW = 3; // Clock source switched
  localparam int EV_RESET = 4; // A reset was seen

  // ------------------------------------------------------------
  // Clock source codes
  // ------------------------------------------------------------
  localparam logic [1:0] CSS_PRIMARY = 2'h0;
  localparam logic [1:0] CSS_SECONDARY = 2'h1;
  localparam logic [1:0] CSS_INTERNAL = 2'h2; // Any 1x value maps here

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PIN_FILTER_NS = 200; // Shortest low level taken as a reset
  localparam int PIN_FILTER_CYC = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PMRC_RUN,
    PMRC_IDLE,
    PMRC_SLEEP
  } pmrc_mode_t;

  typedef enum logic [3:0] {
    CAUSE_POWER_ON,
    CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_WATCHDOG,
    CAUSE_BROWN_OUT,
    CAUSE_RESET_INSTR,
    CAUSE_STACK_FULL,
    CAUSE_STACK_UNDER
  } pmrc_cause_t;

  // Clock gating bundle towards the clock tree
  typedef struct packed {
    logic cpuEn; // CPU clock running
    logic periphEn; // Peripheral clock running
    logic primaryEn; // Primary oscillator on
    logic secondaryEn; // Secondary timer oscillator on
    logic fastEn; // internal_fast_osc on
    logic postEn; // Its postscaler on
    logic slowEn; // internal_slow_osc on
    logic [1:0] src; // Source feeding the system clock
  } pmrc_clk_t;

  // Internal reset requests, one-cycle or level
  typedef struct packed {
    logic watchdog;
    logic brownOut;
    logic resetInstr;
    logic stackFull;
    logic stackUnder;
  } pmrc_rstreq_t;

endpackage

// ==== power_mode_reset_control_bench.sv ====
// Self-checking bench for the power-mode and reset-source control block
`timescale 1ns/1ns
`define CHK(nm, got, exp) chk(nm, 32'(got), 32'(exp));
module power_mode_reset_control_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdVal;
  logic pready, pslverr, errVal;
  logic sleepExec = 1'b0, wakeEvent = 1'b0;
  logic [2:0] srcRunning = 3'h7; // All sources stable
  pmrc_pkg::pmrc_rstreq_t rstReq = '0;
  logic externalResetPinIn = 1'b1, externalResetPinEnable = 1'b1;
  logic externalResetPinOut, externalResetPinOe, pinDigitalIn, sysReset, irq;
  pmrc_pkg::pmrc_clk_t clkCtrl;
  pmrc_pkg::pmrc_mode_t mode;
  // Model state, plain integers
  int n_mismatch = 0, checks_done = 0;
  int seed = 32'h966c7309;
  int expSrc, halt, sel;
  bit seen;

  always #5 clk = ~clk;

  power_mode_reset_control i_power_mode_reset_control (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepExec(sleepExec), .wakeEvent(wakeEvent), .srcRunning(srcRunning), .rstReq(rstReq),
    .externalResetPinIn(externalResetPinIn), .externalResetPinEnable(externalResetPinEnable),
    .externalResetPinOut(externalResetPinOut), .externalResetPinOe(externalResetPinOe),
    .pinDigitalIn(pinDigitalIn), .clkCtrl(clkCtrl), .sysReset(sysReset), .mode(mode), .irq(irq)
  );

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task conclude;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Four-state compare so an unknown never matches
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task timeout(input string nm);
    n_mismatch++;
    $display("ERROR %s expected answer seen none", nm);
    conclude();
  endtask

  // ----------------------------------------
  // APB master: setup, then access held until pready
  // ----------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) timeout("pready");
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // One-cycle pulse on the wake strobe or the sleep strobe
  task pulse(input bit wake);
    @(posedge clk);
    if (wake) wakeEvent <= 1'b1;
    else sleepExec <= 1'b1;
    @(posedge clk);
    wakeEvent <= 1'b0;
    sleepExec <= 1'b0;
    @(posedge clk);
  endtask

  // Watch for a reset pulse; the pin is never driven while it runs
  task watchRst(input int n, output bit hit);
    int k;
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (sysReset === 1'b1) hit = 1'b1;
      `CHK("pinDrive", ({externalResetPinOe, externalResetPinOut}), 2'b00)
    end
    k = 0;
    while (sysReset !== 1'b0 && k < 60) begin @(posedge clk); k++; end
    if (k >= 60) timeout("sysReset release");
  endtask

  // Pin low for n samples, then released
  task holdPin(input int n, output bit hit);
    @(posedge clk); externalResetPinIn <= 1'b0;
    repeat (n) @(posedge clk);
    externalResetPinIn <= 1'b1;
    watchRst(6, hit);
  endtask

  function automatic int srcOf(input int s);
    return (s > 1) ? 2 : s; // Both 1x codes fold onto internal
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("clkCtrl", clkCtrl, 9'h1c0)
    apb(1'b0, pmrc_pkg::OFF_OSC_CTRL, 32'h0); `CHK("osc", rdVal, 32'h0)
    apb(1'b0, pmrc_pkg::OFF_RST_CTRL, 32'h0); `CHK("rstCtrl", rdVal, 32'h0)
    apb(1'b0, pmrc_pkg::OFF_IRQ_STAT, 32'h0); `CHK("irqStat", rdVal, 32'h0)
    apb(1'b1, pmrc_pkg::OFF_RST_CTRL, 32'h2);
    apb(1'b1, pmrc_pkg::OFF_RST_CTRL, 32'h0); // Writing zero must not clear it
    apb(1'b0, pmrc_pkg::OFF_RST_CTRL, 32'h0); `CHK("porFlag", rdVal, 32'h2)
    // Unmapped place and a read-only place
    apb(1'b0, 8'h18, 32'h0); `CHK("slvErr", errVal, 1'b1)
    `CHK("slvData", rdVal, 32'h0)
    apb(1'b1, pmrc_pkg::OFF_MODE, 32'h33);
    apb(1'b0, pmrc_pkg::OFF_MODE, 32'h0); `CHK("modeRo", rdVal, 32'h0)
    `CHK("modeErr", errVal, 1'b0)
    apb(1'b1, pmrc_pkg::OFF_IRQ_EN, 32'h1 << pmrc_pkg::EV_WAKE);
    pulse(1'b1); `CHK("wakeInRun", mode, pmrc_pkg::PMRC_RUN)
    // Source not yet running: old source stays until it starts
    srcRunning <= 3'h5;
    apb(1'b1, pmrc_pkg::OFF_OSC_CTRL, 32'h1);
    repeat (3) @(posedge clk); `CHK("srcWait", clkCtrl.src, 2'h0)
    srcRunning <= 3'h7;
    repeat (3) @(posedge clk); `CHK("srcLate", clkCtrl.src, 2'h1)
    // Every select code with both halt settings
    for (int i = 0; i < 8; i++) begin
      sel = i % 4;
      halt = i / 4;
      expSrc = srcOf(sel);
      apb(1'b1, pmrc_pkg::OFF_OSC_CTRL, 32'((halt << 7) | sel));
      repeat (2) @(posedge clk);
      `CHK("src", clkCtrl.src, expSrc)
      `CHK("runClk", ({clkCtrl.cpuEn, clkCtrl.periphEn}), 2'b11)
      `CHK("srcEn", ({clkCtrl.primaryEn, clkCtrl.secondaryEn}), ({expSrc == 0, expSrc == 1}))
      if (expSrc == 2) `CHK("intBlk", ({clkCtrl.fastEn, clkCtrl.postEn, clkCtrl.slowEn}), 3'h7)
      apb(1'b0, pmrc_pkg::OFF_MODE, 32'h0); `CHK("modeReg", rdVal, expSrc << 4)
      apb(1'b1, pmrc_pkg::OFF_IRQ_CLR, 32'h1f);
      pulse(1'b0);
      `CHK("lowMode", mode, halt ? pmrc_pkg::PMRC_IDLE : pmrc_pkg::PMRC_SLEEP)
      if (halt == 1) begin
        `CHK("idleClk", ({clkCtrl.cpuEn, clkCtrl.periphEn, clkCtrl.src}), (4 | expSrc))
      end else begin
        `CHK("sleepClk", clkCtrl[8:2], 7'h00)
      end
      // Flipped halt bit and a second sleep must not change the mode
      apb(1'b1, pmrc_pkg::OFF_OSC_CTRL, 32'(((1 - halt) << 7) | sel));
      pulse(1'b0);
      `CHK("sampled", mode, halt ? pmrc_pkg::PMRC_IDLE : pmrc_pkg::PMRC_SLEEP)
      apb(1'b0, pmrc_pkg::OFF_IRQ_STAT, 32'h0); `CHK("evLow", rdVal, 32'h1 << halt)
      `CHK("irqMask", irq, 1'b0)
      repeat ($unsigned($random(seed)) % 8) @(posedge clk);
      pulse(1'b1);
      `CHK("wakeMode", mode, pmrc_pkg::PMRC_RUN)
      `CHK("wakeClk", ({clkCtrl.cpuEn, clkCtrl.src}), (4 | expSrc))
      @(posedge clk); `CHK("irqSet", irq, 1'b1)
      apb(1'b1, pmrc_pkg::OFF_IRQ_CLR, 32'h1 << pmrc_pkg::EV_WAKE);
      @(posedge clk); `CHK("irqClr", irq, 1'b0)
    end
    // Short pin pulses are filtered, long ones reset
    for (int k = 0; k < 3; k++) begin
      holdPin((k == 0) ? 19 : (k == 1) ? 8 : 1 + $unsigned($random(seed)) % 18, seen);
      `CHK("glitch", seen, 1'b0)
    end
    holdPin(30, seen); `CHK("pinRst", seen, 1'b1)
    apb(1'b0, pmrc_pkg::OFF_RST_CTRL, 32'h0); `CHK("causeRun", rdVal, 32'h102)
    apb(1'b0, pmrc_pkg::OFF_IRQ_STAT, 32'h0); `CHK("rstEv", rdVal[4], 1'b1)
    pulse(1'b0);
    holdPin(30, seen);
    apb(1'b0, pmrc_pkg::OFF_RST_CTRL, 32'h0); `CHK("causeSlp", rdVal, 32'h202)
    `CHK("rstMode", mode, pmrc_pkg::PMRC_RUN)
    // Reset function disabled: pin is a plain input
    externalResetPinEnable <= 1'b0;
    holdPin(30, seen); `CHK("pinOff", seen, 1'b0)
    `CHK("digIn", pinDigitalIn, 1'b1)
    externalResetPinIn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("digLow", pinDigitalIn, 1'b0)
    externalResetPinIn <= 1'b1;
    externalResetPinEnable <= 1'b1;
    // Each internal request: cause recorded, flag untouched
    for (int i = 0; i < 5; i++) begin
      @(posedge clk); rstReq <= pmrc_pkg::pmrc_rstreq_t'(5'h1 << i);
      @(posedge clk); rstReq <= '0;
      watchRst(4, seen); `CHK("intRst", seen, 1'b1)
      apb(1'b0, pmrc_pkg::OFF_RST_CTRL, 32'h0); `CHK("cause", rdVal, 32'(((7 - i) << 8) | 2))
    end
    // A second power-on clears the flag again
    @(posedge clk); rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, pmrc_pkg::OFF_RST_CTRL, 32'h0); `CHK("porAgain", rdVal, 32'h0)
    conclude();
  end
endmodule
